// ===== verilog/acmc_analog_comparator_mode_control.sv
/*
  Digital control around one analog comparator: mode decode, pin
  functions, polarity, input switch, change flag and an AXI4-Lite slave.
  Assumes the comparator output arrives asynchronously and that the three
  shared pins are plus input (0), minus input (1) and result output (2).
*/
`timescale 1ns/1ps
`default_nettype none
`include "acmc_defs.svh"

module acmc_analog_comparator_mode_control
  import acmc_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clkEn,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog comparator core
  input wire logic compareRaw,
  output logic comparatorEnable,
  output logic inputSwitchSelect,
  output logic referenceSelect,
  // Shared port pins: 0 plus input, 1 minus input, 2 result output
  input wire logic [2:0] pinIn,
  output logic [2:0] pinOut,
  output logic [2:0] pinOe,
  output logic [2:0] pinPortOut,
  output logic [2:0] pinInputBufEn,
  // Interrupt
  output logic irq
);

  // ==========================================================
  // Mode decode
  // ==========================================================
  // Bit order of the returned mask: 0 plus, 1 minus, 2 result pin
  function automatic logic [2:0] analogPins(input acmc_mode_e m);
    case (m)
      ACMC_MODE_RESET: analogPins = 3'h3;
      ACMC_MODE_OUT: analogPins = 3'h3;
      ACMC_MODE_NOOUT: analogPins = 3'h3;
      ACMC_MODE_OUT_REF: analogPins = 3'h2;
      ACMC_MODE_REF: analogPins = 3'h3;
      ACMC_MODE_MUX_OUT: analogPins = 3'h3;
      ACMC_MODE_MUX_REF: analogPins = 3'h3;
      default: analogPins = 3'h0;
    endcase
  endfunction : analogPins

  function automatic logic drivesPin(input acmc_mode_e m);
    drivesPin = (m == ACMC_MODE_OUT) || (m == ACMC_MODE_OUT_REF) ||
      (m == ACMC_MODE_MUX_OUT);
  endfunction : drivesPin

  function automatic logic isOff(input acmc_mode_e m);
    isOff = (m == ACMC_MODE_RESET) || (m == ACMC_MODE_OFF);
  endfunction : isOff

  // ==========================================================
  // State
  // ==========================================================
  acmc_state_s state_reg;
  acmc_state_s state_next;

  logic [2:0] analogMask;
  logic compareResult;
  logic awGo;
  logic arGo;
  logic wrConfig;
  logic rdConfig;
  logic [31:0] configWord;

  // Off modes leave the raw value meaningless, so force 0 before inversion
  assign analogMask = analogPins(state_reg.modeSelect);
  assign compareResult = (state_reg.syncB & ~isOff(state_reg.modeSelect))
    ^ state_reg.polarityInvert;

  assign configWord = {25'h0, compareResult, 1'b0,
    state_reg.polarityInvert, state_reg.inputSwitchSelect,
    state_reg.modeSelect};

  // Write address and data are taken together only, in the idle state
  // No handshake while frozen, or a transfer would be lost
  assign awGo = clkEn && s_axi_awvalid && s_axi_wvalid &&
    (state_reg.wrState == ACMC_WR_IDLE);
  assign arGo = clkEn && s_axi_arvalid && !state_reg.rValid;
  assign wrConfig = awGo && (s_axi_awaddr == `ACMC_OFF_CONFIG);
  assign rdConfig = arGo && (s_axi_araddr == `ACMC_OFF_CONFIG);

  always_comb begin
    state_next = state_reg;
    // Two-flop synchroniser; only syncB is read anywhere
    state_next.syncA = compareRaw;
    state_next.syncB = state_reg.syncA;
    // Pin levels are asynchronous: two flops before the port data
    state_next.pinSyncA = pinIn;
    state_next.pinSyncB = state_reg.pinSyncA;
    // Analog pins read 0 in the port data
    state_next.portData = state_reg.pinSyncB & ~analogMask;

    // Reads and writes of the configuration refresh the mismatch latch
    if (rdConfig || wrConfig) begin
      state_next.latchedResult = compareResult;
    end

    // Write channel
    if (state_reg.wrState == ACMC_WR_RESP) begin
      if (s_axi_bready) begin
        state_next.wrState = ACMC_WR_IDLE;
      end
    end else if (awGo) begin
      state_next.wrState = ACMC_WR_RESP;
      state_next.bResp = `ACMC_RESP_OKAY;
      if (s_axi_awaddr == `ACMC_OFF_CONFIG) begin
        if (s_axi_wstrb[0]) begin
          state_next.modeSelect = acmc_mode_e'(
            s_axi_wdata[`ACMC_MODE_MSB:`ACMC_MODE_LSB]);
          state_next.inputSwitchSelect =
            s_axi_wdata[`ACMC_BIT_SWITCH];
          state_next.polarityInvert = s_axi_wdata[`ACMC_BIT_INVERT];
        end
      end else if (s_axi_awaddr == `ACMC_OFF_INT_STAT) begin
        if (s_axi_wstrb[0] && s_axi_wdata[`ACMC_INT_CHANGE]) begin
          state_next.changeFlag = 1'b0;
        end
      end else if (s_axi_awaddr == `ACMC_OFF_INT_MASK) begin
        if (s_axi_wstrb[0]) begin
          state_next.changeMask = s_axi_wdata[`ACMC_INT_CHANGE];
        end
      end else if (s_axi_awaddr == `ACMC_OFF_PORT_DIR) begin
        if (s_axi_wstrb[0]) begin
          state_next.pinDirection = s_axi_wdata[2:0];
        end
      end else begin
        state_next.bResp = `ACMC_RESP_SLVERR;
      end
    end

    // Mismatch sets the flag; set wins over a same-cycle clear
    if (compareResult != state_reg.latchedResult) begin
      state_next.changeFlag = 1'b1;
    end

    // Read channel
    if (state_reg.rValid) begin
      if (s_axi_rready) begin
        state_next.rValid = 1'b0;
      end
    end else if (arGo) begin
      state_next.rValid = 1'b1;
      state_next.rResp = `ACMC_RESP_OKAY;
      if (s_axi_araddr == `ACMC_OFF_CONFIG) begin
        state_next.rData = configWord;
      end else if (s_axi_araddr == `ACMC_OFF_INT_STAT) begin
        state_next.rData = {31'h0, state_reg.changeFlag};
      end else if (s_axi_araddr == `ACMC_OFF_INT_MASK) begin
        state_next.rData = {31'h0, state_reg.changeMask};
      end else if (s_axi_araddr == `ACMC_OFF_PORT_DIR) begin
        state_next.rData = {26'h0, state_reg.portData,
          state_reg.pinDirection};
      end else begin
        state_next.rData = 32'h0;
        state_next.rResp = `ACMC_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg.syncA <= 1'b0;
      state_reg.syncB <= 1'b0;
      state_reg.pinSyncA <= 3'h0;
      state_reg.pinSyncB <= 3'h0;
      state_reg.latchedResult <= 1'b0;
      state_reg.changeFlag <= 1'b0;
      state_reg.changeMask <= 1'b0;
      state_reg.modeSelect <= acmc_mode_e'(`ACMC_CONFIG_RST);
      state_reg.polarityInvert <= 1'b0;
      state_reg.inputSwitchSelect <= 1'b0;
      state_reg.pinDirection <= `ACMC_DIR_RST;
      state_reg.wrState <= ACMC_WR_IDLE;
      state_reg.rValid <= 1'b0;
      state_reg.rData <= 32'h0;
      state_reg.rResp <= `ACMC_RESP_OKAY;
      state_reg.bResp <= `ACMC_RESP_OKAY;
      state_reg.portData <= 3'h0;
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign s_axi_awready = awGo;
  assign s_axi_wready = awGo;
  assign s_axi_bvalid = (state_reg.wrState == ACMC_WR_RESP);
  assign s_axi_bresp = state_reg.bResp;
  assign s_axi_arready = arGo;
  assign s_axi_rvalid = state_reg.rValid;
  assign s_axi_rdata = state_reg.rData;
  assign s_axi_rresp = state_reg.rResp;

  assign comparatorEnable = ~isOff(state_reg.modeSelect);
  // Switch is meaningful only in the multiplexed modes
  assign inputSwitchSelect = state_reg.inputSwitchSelect &&
    ((state_reg.modeSelect == ACMC_MODE_MUX_OUT) ||
     (state_reg.modeSelect == ACMC_MODE_MUX_REF));
  assign referenceSelect = (state_reg.modeSelect == ACMC_MODE_OUT_REF) ||
    (state_reg.modeSelect == ACMC_MODE_REF) ||
    (state_reg.modeSelect == ACMC_MODE_MUX_OUT) ||
    (state_reg.modeSelect == ACMC_MODE_MUX_REF);

  assign pinInputBufEn = ~analogMask;
  assign pinPortOut = state_reg.portData;

  // Pin 2 carries the result when routed, regardless of direction bit
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      if (gi == 2) begin : g_res
        assign pinOut[gi] = drivesPin(state_reg.modeSelect) ?
          compareResult : 1'b0;
        assign pinOe[gi] = drivesPin(state_reg.modeSelect);
      end else begin : g_io
        assign pinOut[gi] = 1'b0;
        assign pinOe[gi] = 1'b0;
      end
    end
  endgenerate

  assign irq = state_reg.changeFlag & state_reg.changeMask;

endmodule : acmc_analog_comparator_mode_control
`default_nettype wire

// ===== verilog/acmc_defs.svh
/*
  Offsets, field positions, response codes and reset values of the comparator
  mode control block. Assumes inclusion by bare name from design files.
*/
`ifndef ACMC_DEFS_SVH
`define ACMC_DEFS_SVH

`define ACMC_OFF_CONFIG 4'h0
`define ACMC_OFF_INT_STAT 4'h4
`define ACMC_OFF_INT_MASK 4'h8
`define ACMC_OFF_PORT_DIR 4'hC

`define ACMC_BIT_RESULT 6
`define ACMC_BIT_INVERT 4
`define ACMC_BIT_SWITCH 3
`define ACMC_MODE_LSB 0
`define ACMC_MODE_MSB 2

`define ACMC_INT_CHANGE 0

`define ACMC_CONFIG_RST 3'h0
`define ACMC_DIR_RST 3'h7

`define ACMC_RESP_OKAY 2'h0
`define ACMC_RESP_SLVERR 2'h2

`endif

// ===== verilog/acmc_pkg.sv
/*
  Types of the comparator mode control block.
  Assumes acmc_defs.svh is on the include path.
*/
package acmc_pkg;

  typedef enum logic [2:0] {
    ACMC_MODE_RESET = 3'b000,
    ACMC_MODE_OUT = 3'b001,
    ACMC_MODE_NOOUT = 3'b010,
    ACMC_MODE_OUT_REF = 3'b011,
    ACMC_MODE_REF = 3'b100,
    ACMC_MODE_MUX_OUT = 3'b101,
    ACMC_MODE_MUX_REF = 3'b110,
    ACMC_MODE_OFF = 3'b111
  } acmc_mode_e;

  typedef enum logic [0:0] {
    ACMC_WR_IDLE = 1'b0,
    ACMC_WR_RESP = 1'b1
  } acmc_wr_e;

  typedef struct packed {
    logic syncA;
    logic syncB;
    logic [2:0] pinSyncA;
    logic [2:0] pinSyncB;
    logic latchedResult;
    logic changeFlag;
    logic changeMask;
    acmc_mode_e modeSelect;
    logic polarityInvert;
    logic inputSwitchSelect;
    logic [2:0] pinDirection;
    acmc_wr_e wrState;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [1:0] bResp;
    logic [2:0] portData;
  } acmc_state_s;

endpackage : acmc_pkg

// ===== verif/acmc_far_side.sv
/* Far-side model: comparator core and shared pins.
   Assumes analog levels and pin levels are set by the bench. */
`timescale 1ns/1ps
`default_nettype none
module acmc_far_side (
  // Design side
  input wire logic comparatorEnable,
  input wire logic inputSwitchSelect,
  input wire logic [2:0] pinOut,
  input wire logic [2:0] pinOe,
  output logic compareRaw,
  output logic [2:0] pinIn,
  // Bench side
  input wire logic [7:0] vPlus,
  input wire logic [7:0] vMinA,
  input wire logic [7:0] vMinB,
  input wire logic [2:0] extPin
);
  // Idle core floats high, so the design must mask it
  assign compareRaw = !comparatorEnable ? 1'b1 :
    vPlus > (inputSwitchSelect ? vMinB : vMinA);
  assign pinIn = (pinOe & pinOut) | (~pinOe & extPin);
endmodule : acmc_far_side
`default_nettype wire

// ===== verif/acmc_assertions.sv
/* Port checker of the comparator control block.
   Assumes it is bound onto the top module. */
`timescale 1ns/1ps
`default_nettype none
module acmc_assertions (
  // Clock, reset, enable, write address ready
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic s_axi_awready,
  // Comparator and pins
  input wire logic compareRaw,
  input wire logic comparatorEnable,
  input wire logic inputSwitchSelect,
  input wire logic [2:0] pinOut,
  input wire logic [2:0] pinOe,
  input wire logic [2:0] pinPortOut,
  input wire logic [2:0] pinInputBufEn,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ====================
  // Rules
  property p_rst; $fell(srst) |-> !comparatorEnable && !irq && !pinOe; endproperty
  a_rst: assert property (p_rst)
    else $error("not idle after reset");
  property p_in; pinOe[1:0] == 2'h0; endproperty
  a_in: assert property (p_in)
    else $error("input pin driven");
  property p_oe; pinOe[2] |-> comparatorEnable; endproperty
  a_oe: assert property (p_oe)
    else $error("result pin driven while off");
  property p_off; !comparatorEnable |-> !pinOut[2] && !pinOe[2]; endproperty
  a_off: assert property (p_off)
    else $error("off mode drives result pin");
  property p_an; (~pinInputBufEn & ~$past(pinInputBufEn) & pinPortOut) == 3'h0;
  endproperty
  a_an: assert property (p_an)
    else $error("analog pin reads one");
  property p_sw; inputSwitchSelect |-> comparatorEnable; endproperty
  a_sw: assert property (p_sw)
    else $error("switch outside its modes");
  property p_swa; inputSwitchSelect |-> pinInputBufEn[1:0] == 2'h0; endproperty
  a_swa: assert property (p_swa)
    else $error("switched pin not analog");
  // Two-flop path: raw still for four cycles leaves the pin still
  sequence s_quiet; !s_axi_awready && clkEn && $stable(compareRaw); endsequence
  property p_sync; s_quiet [*4] |-> $stable(pinOut[2]); endproperty
  a_sync: assert property (p_sync)
    else $error("result pin moved without cause");
  c_oe: cover property (pinOe[2]);
  c_sw: cover property (inputSwitchSelect);
  c_irq: cover property (irq);
endmodule : acmc_assertions
bind acmc_analog_comparator_mode_control acmc_assertions u_chk (
  .clk_sys(clk_sys), .srst(srst), .clkEn(clkEn), .s_axi_awready(s_axi_awready),
  .compareRaw(compareRaw), .comparatorEnable(comparatorEnable),
  .inputSwitchSelect(inputSwitchSelect), .pinOut(pinOut), .pinOe(pinOe),
  .pinPortOut(pinPortOut), .pinInputBufEn(pinInputBufEn), .irq(irq));
`default_nettype wire

// ===== verif/tb.sv
/* Bench: AXI4-Lite tasks, mode sweep, input switch, change interrupt.
   Assumes the design, far-side model and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
  logic clk_sys, srst, clkEn, awv, wv, br, arv, rr, awR, bv, arR, rv;
  logic raw, en, sw, irq, inv, on, res, ob, rs;
  logic [3:0] awa, ara;
  logic [31:0] wd, rd, d;
  logic [1:0] bresp, rresp, r;
  logic [2:0] po, oe, pp, be, pin, ext, m, bx, px;
  logic [7:0] vp, va, vb;
  int errors, n_checks;
  acmc_analog_comparator_mode_control uut (.clk_sys(clk_sys), .srst(srst),
    .clkEn(clkEn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awR), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arR), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .compareRaw(raw), .comparatorEnable(en), .inputSwitchSelect(sw),
    .referenceSelect(rs), .pinIn(pin), .pinOut(po), .pinOe(oe),
    .pinPortOut(pp), .pinInputBufEn(be), .irq(irq));
  acmc_far_side far (.comparatorEnable(en), .inputSwitchSelect(sw),
    .pinOut(po), .pinOe(oe), .compareRaw(raw), .pinIn(pin), .vPlus(vp),
    .vMinA(va), .vMinB(vb), .extPin(ext));
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ====================
  // Bus tasks
  task automatic wr(input logic [3:0] a, input logic [31:0] v,
    input logic [1:0] e);
    logic hit;
    logic [1:0] s;
    // Ready is sampled settled, mid-cycle, then the edge takes it
    awa <= a; wd <= v; awv <= 1; wv <= 1;
    hit = 0;
    while (!hit) begin
      @(negedge clk_sys);
      hit = awR;
      @(posedge clk_sys);
    end
    awv <= 0; wv <= 0; br <= 1;
    hit = 0;
    while (!hit) begin
      @(negedge clk_sys);
      hit = bv;
      s = bresp;
      @(posedge clk_sys);
    end
    br <= 0;
    `CHK("bresp", e, s)
  endtask : wr
  task automatic rdr(input logic [3:0] a);
    logic hit;
    ara <= a; arv <= 1;
    hit = 0;
    while (!hit) begin
      @(negedge clk_sys);
      hit = arR;
      @(posedge clk_sys);
    end
    arv <= 0; rr <= 1;
    hit = 0;
    while (!hit) begin
      @(negedge clk_sys);
      hit = rv;
      d = rd;
      r = rresp;
      @(posedge clk_sys);
    end
    rr <= 0;
  endtask : rdr
  task automatic chk(input logic [3:0] a, input logic [31:0] k,
    input logic [31:0] e, input string n);
    rdr(a);
    `CHK(n, e, d & k)
  endtask : chk
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  // Tests take a few hundred cycles; allow 20000
  initial begin
    #2000000;
    errors++;
    end_sim;
  end
  initial begin
    srst = 1; clkEn = 1; awv = 0; wv = 0; br = 0; arv = 0; rr = 0;
    awa = 0; ara = 0; wd = 0; vp = 8'hC0; va = 8'h40; vb = 8'hF0; ext = 3'h7;
    repeat (12) @(posedge clk_sys);
    srst <= 0;
    @(posedge clk_sys);
    chk(4'h0, 32'hFF, 32'h0, "cfg");
    chk(4'hC, 32'h3F, 32'h27, "dir");
    for (int i = 0; i < 16; i++) begin
      m = i[2:0]; inv = i[3];
      ob = m == 3'h1 || m == 3'h3 || m == 3'h5;
      wr(4'hC, {29'h0, !ob, 2'h3}, 2'h0);
      wr(4'h0, {27'h0, inv, 1'b0, m}, 2'h0); // Mask still clear
      repeat (6) @(posedge clk_sys);
      on = m != 3'h0 && m != 3'h7;
      res = (on & (vp > va)) ^ inv;
      bx = m == 3'h7 ? 3'h7 : m == 3'h3 ? 3'h5 : 3'h4;
      px = bx & {ob ? res : 1'b1, 2'h3};
      `CHK("en", on, en)
      `CHK("ref", m == 3'h3 || m == 3'h4 || m == 3'h5 || m == 3'h6, rs)
      `CHK("pp", px, pp)
      `CHK("oe", ob, oe[2])
      `CHK("pin", ob & res, po[2])
      `CHK("buf", bx, be)
      chk(4'h0, 32'h40, {25'h0, res, 6'h0}, "res");
      chk(4'hC, 32'h38, {26'h0, bx & {ob ? res : 1'b1, 2'h3}, 3'h0}, "port");
    end
    wr(4'h0, 32'h0D, 2'h0);
    repeat (4) @(posedge clk_sys);
    `CHK("sw", 1'b1, sw)
    `CHK("swbuf", 3'h4, be)
    chk(4'h0, 32'h40, 32'h0, "swres");
    wr(4'h0, 32'h09, 2'h0);
    `CHK("swoff", 1'b0, sw)
    repeat (4) @(posedge clk_sys);
    chk(4'h0, 32'h40, 32'h40, "latch");
    wr(4'h4, 32'h1, 2'h0);
    wr(4'h8, 32'h1, 2'h0);
    `CHK("irq0", 1'b0, irq)
    vp <= 8'h10;
    repeat (4) @(posedge clk_sys);
    `CHK("irq1", 1'b1, irq)
    wr(4'h4, 32'h1, 2'h0);
    `CHK("sticky", 1'b1, irq)
    wr(4'h8, 32'h0, 2'h0);
    `CHK("masked", 1'b0, irq)
    chk(4'h0, 32'h40, 32'h0, "relatch");
    wr(4'h4, 32'h1, 2'h0);
    chk(4'h4, 32'h1, 32'h0, "cleared");
    rdr(4'h2);
    `CHK("rresp", 2'h2, r)
    `CHK("rdata", 32'h0, d)
    wr(4'h6, 32'h0, 2'h2);
    wr(4'h0, 32'h15, 2'h0);
    srst <= 1;
    @(posedge clk_sys);
    srst <= 0;
    @(posedge clk_sys);
    chk(4'h0, 32'h1F, 32'h0, "rst2");
    end_sim;
  end
endmodule : tb
`default_nettype wire
